// >>> pkg/ulc_pkg.sv
// Constants, types and timing for the two-port current limit controller.
// Assumes a 10 MHz system clock and comparator inputs from analog sense circuits.
package ulc_pkg;

    // ****************************************************************
    // Clock and timebase
    // ****************************************************************
    localparam int CLOCK_HZ = 10_000_000;
    localparam int TICK_US = 100;
    localparam int TICK_CYCLES = CLOCK_HZ / 1_000_000 * TICK_US;

    // ****************************************************************
    // Protection timing, in microseconds and in timebase ticks; fast turnoff in nanoseconds and clock cycles
    // ****************************************************************
    localparam int BOOST_WINDOW_US = 2000;
    localparam int BOOST_REARM_US = 16000;
    localparam int PERSIST_US = 4100;
    localparam int HICCUP_OFF_US = 524000;
    localparam int SOFT_START_US = 1000;
    localparam int FAST_RECOVER_US = 100;
    localparam int FAST_OFF_NS = 600;
    localparam int FAST_OFF_CYCLES = FAST_OFF_NS / (1_000_000_000 / CLOCK_HZ);
    localparam logic [12:0] BOOST_TICKS = 13'(BOOST_WINDOW_US / TICK_US);
    localparam logic [12:0] REARM_TICKS = 13'(BOOST_REARM_US / TICK_US);
    localparam logic [12:0] PERSIST_TICKS = 13'(PERSIST_US / TICK_US);
    localparam int HICCUP_OFF_TICKS = HICCUP_OFF_US / TICK_US;
    localparam logic [12:0] SS_TICKS = 13'(SOFT_START_US / TICK_US);
    localparam logic [12:0] FAST_TICKS = 13'(FAST_RECOVER_US / TICK_US);

    // ****************************************************************
    // Current limit setting
    // ****************************************************************
    localparam logic [15:0] PRIMARY_DEFAULT_MA = 16'h0DDE;
    localparam int LIMIT_K_KOHM_MA = 32273;
    localparam int RES_LSB_PER_KOHM = 10;
    localparam int SEC_NUM = 8;
    localparam int SEC_DEN = 5;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_OFF, ST_SOFT, ST_RUN, ST_FAST_OFF, ST_HICCUP, ST_HOT
    } ulc_state_t;

    typedef struct packed {
        logic en;
        logic over_pri;
        logic over_sec;
        logic over_fast;
        logic hot;
        logic cooled;
        logic vbus_good;
    } ulc_sense_t;

endpackage : ulc_pkg

// >>> hdl/ulc_port_ctrl.sv
// Two-port current limit, short-circuit, hiccup and thermal control logic.
// Assumes comparator, temperature and pin levels are asynchronous and static resistor code.
// Contract
// - After power-up each port starts on the secondary limit for the boost window.
// - After the boost ends the secondary limit re-arms only after the re-arm delay.
// - Current above the secondary limit ends the boost window immediately.
// - Current near 8 A switches the port off within the fast turnoff time.
// - After fast turnoff the port restarts through soft-start, then limits at primary.
// - Current between the two limits passes unlimited during the boost window.
// - While limiting at primary, current is held and voltage follows the load.
// - Limiting over 4.1 ms gives hiccup: 524 ms off, 4.1 ms on, repeating; a retry re-armed during the off time boosts 2 ms first, up to 6.1 ms on.
// - Each port runs its own protection independent of the other, except for the secondary-limit interlock.
// - NFET above 160 C turns the switch off until it cools 10 C.
// - A port above primary removes the other port's secondary limit at once.
// - Grounded limit input gives 3.55 A, else 32273 over the resistor.
// - Output rises under soft-start control to limit inrush.
// - Fault flag low in hiccup or thermal off, released once recovered.
// - Enable high turns the switch on; low turns it off with discharge.
module ulc_port_ctrl
    import ulc_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYCLES,
    parameter int HIC_TICKS = HICCUP_OFF_TICKS
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic uvlo_ok,
    input wire logic limit_set_gnd,
    input wire logic [11:0] limit_set_resistor,
    input wire logic [1:0] port_enable_input,
    input wire logic [1:0] over_primary,
    input wire logic [1:0] over_secondary,
    input wire logic [1:0] over_fast,
    input wire logic [1:0] nfet_hot,
    input wire logic [1:0] nfet_cooled,
    input wire logic [1:0] vbus_good,
    output logic [1:0] switch_on,
    output logic [1:0] soft_start,
    output logic [1:0] discharge,
    output logic [1:0] secondary_sel,
    output logic [1:0] limiting,
    output logic [1:0] port_fault_flag_out,
    output logic [1:0] port_fault_flag_oe,
    output logic [15:0] primary_limit,
    output logic [15:0] secondary_limit
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Resistor code is in 100 ohm steps; zero is treated as the default.
    function automatic logic [15:0] limit_ma(input logic gnd, input logic [11:0] res);
        logic [19:0] q;
        q = 20'h00000;
        if (gnd || res == 12'h000) begin
            q = {4'h0, PRIMARY_DEFAULT_MA};
        end else begin
            q = 20'(LIMIT_K_KOHM_MA * RES_LSB_PER_KOHM) / {8'h00, res};
        end
        return q[15:0];
    endfunction

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int SW = 2 * $bits(ulc_sense_t) + 2;
    logic [SW-1:0] raw, s1_reg, s2_reg, s3_reg, flt_reg, flt_next;
    ulc_sense_t sen [2];
    logic uvlo_q, gnd_q;

    assign raw = {uvlo_ok, limit_set_gnd,
                  port_enable_input[1], over_primary[1], over_secondary[1], over_fast[1],
                  nfet_hot[1], nfet_cooled[1], vbus_good[1],
                  port_enable_input[0], over_primary[0], over_secondary[0], over_fast[0],
                  nfet_hot[0], nfet_cooled[0], vbus_good[0]};

    // A bit is accepted only once the second and third stages agree, which rejects one-cycle glitches.
    always_comb begin
        for (int b = 0; b < SW; b++) begin
            flt_next[b] = (s2_reg[b] == s3_reg[b]) ? s3_reg[b] : flt_reg[b];
        end
    end

    // Three-stage chain; the first stage feeds only the second.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            flt_reg <= '0;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            flt_reg <= flt_next;
        end
    end

    assign sen[0] = flt_reg[6:0];
    assign sen[1] = flt_reg[13:7];
    assign uvlo_q = flt_reg[15];
    assign gnd_q = flt_reg[14];

    // ****************************************************************
    // Free-running timebase
    // ****************************************************************
    logic [15:0] tb_reg, tb_next;
    logic tick_reg, tick_next;

    // One shared tick keeps both ports on the same time grid.
    always_comb begin
        tick_next = (tb_reg == 16'(TICK_CYC - 1));
        tb_next = tick_next ? 16'h0000 : tb_reg + 16'h0001;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tb_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            tb_reg <= tb_next;
            tick_reg <= tick_next;
        end
    end

    // ****************************************************************
    // Limit thresholds
    // ****************************************************************
    logic [15:0] pri_next, sec_next;

    always_comb begin
        pri_next = limit_ma(gnd_q, limit_set_resistor);
        sec_next = 16'(({4'h0, pri_next} * 20'(SEC_NUM)) / 20'(SEC_DEN));
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            primary_limit <= PRIMARY_DEFAULT_MA;
            secondary_limit <= 16'h0000;
        end else begin
            primary_limit <= pri_next;
            secondary_limit <= sec_next;
        end
    end

    // ****************************************************************
    // Per-port protection state
    // ****************************************************************
    ulc_state_t st_reg [2], st_next [2];
    logic [12:0] tmr_reg [2], tmr_next [2];
    logic [12:0] bst_reg [2], bst_next [2];
    logic [12:0] rearm_reg [2], rearm_next [2];
    logic [12:0] lim_reg [2], lim_next [2];
    logic [1:0] boost_reg, boost_next, armed_reg, armed_next, fault_reg, fault_next;
    logic [1:0] lim_now;

    // Each port is evaluated with its own sense bits; the only coupling is the interlock.
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            st_next[p] = st_reg[p];
            tmr_next[p] = tick_reg ? tmr_reg[p] + 13'h0001 : tmr_reg[p];
            bst_next[p] = bst_reg[p];
            rearm_next[p] = rearm_reg[p];
            lim_next[p] = lim_reg[p];
            boost_next[p] = boost_reg[p];
            armed_next[p] = armed_reg[p];
            // Between the limits the switch passes current while boosted.
            // Limiting also counts during soft start, so a hiccup retry stays on for the persistence time, after the boost window if it re-armed while off.
            lim_now[p] = sen[p].over_pri && !boost_reg[p] && (st_reg[p] == ST_SOFT || st_reg[p] == ST_RUN);
            case (st_reg[p])
                ST_OFF: begin
                    if (uvlo_q && sen[p].en) begin
                        st_next[p] = ST_SOFT;
                    end
                end
                ST_SOFT, ST_RUN: begin
                    if (lim_now[p] && tick_reg && lim_reg[p] >= PERSIST_TICKS - 13'h0001) begin
                        st_next[p] = ST_HICCUP;
                    end else if (st_reg[p] == ST_SOFT && tick_reg && tmr_reg[p] >= SS_TICKS - 13'h0001) begin
                        st_next[p] = ST_RUN;
                    end
                end
                ST_FAST_OFF: begin
                    if (tick_reg && tmr_reg[p] >= FAST_TICKS - 13'h0001) begin
                        st_next[p] = ST_SOFT;
                    end
                end
                ST_HICCUP: begin
                    if (tick_reg && tmr_reg[p] >= 13'(HIC_TICKS - 1)) begin
                        st_next[p] = ST_SOFT;
                    end
                end
                ST_HOT: begin
                    if (sen[p].cooled) begin
                        st_next[p] = ST_SOFT;
                    end
                end
                default: st_next[p] = ST_OFF;
            endcase
            // Thermal and short-circuit trips override the normal flow.
            if (st_reg[p] == ST_SOFT || st_reg[p] == ST_RUN) begin
                if (sen[p].hot) begin
                    st_next[p] = ST_HOT;
                end else if (sen[p].over_fast) begin
                    st_next[p] = ST_FAST_OFF;
                end
            end
            if (!uvlo_q || !sen[p].en) begin
                st_next[p] = ST_OFF;
            end
            if (st_next[p] != st_reg[p]) begin
                tmr_next[p] = 13'h0000;
            end
            // Persistence counts only continuous limiting.
            if (!lim_now[p]) begin
                lim_next[p] = 13'h0000;
            end else if (tick_reg) begin
                lim_next[p] = lim_reg[p] + 13'h0001;
            end
            // Boost window and re-arm delay.
            if (boost_reg[p]) begin
                if (tick_reg) begin
                    bst_next[p] = bst_reg[p] + 13'h0001;
                end
                if (sen[p].over_sec || sen[1-p].over_pri || st_next[p] != st_reg[p] && st_next[p] != ST_RUN
                    || (tick_reg && bst_reg[p] >= BOOST_TICKS - 13'h0001)) begin
                    boost_next[p] = 1'b0;
                    armed_next[p] = 1'b0;
                    rearm_next[p] = 13'h0000;
                end
            end else if (!armed_reg[p]) begin
                if (tick_reg) begin
                    rearm_next[p] = rearm_reg[p] + 13'h0001;
                end
                if (tick_reg && rearm_reg[p] >= REARM_TICKS - 13'h0001) begin
                    armed_next[p] = 1'b1;
                end
            end else if (st_next[p] == ST_SOFT || st_next[p] == ST_RUN) begin
                // A waiting arm is held back while the other port is above primary.
                if (!sen[1-p].over_pri) begin
                    boost_next[p] = 1'b1;
                    bst_next[p] = 13'h0000;
                end
            end
            // Setting the fault wins over releasing it in the same cycle.
            fault_next[p] = fault_reg[p];
            if (st_next[p] == ST_HICCUP || st_next[p] == ST_HOT) begin
                fault_next[p] = 1'b1;
            end else if (st_reg[p] == ST_RUN && !sen[p].over_pri && sen[p].vbus_good) begin
                fault_next[p] = 1'b0;
            end
        end
    end

    // Registers for both ports; outputs except limiting and the constant-low port_fault_flag_out are decoded from the next state, and all leave flip-flops.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int p = 0; p < 2; p++) begin
                st_reg[p] <= ST_OFF;
                tmr_reg[p] <= 13'h0000;
                bst_reg[p] <= 13'h0000;
                rearm_reg[p] <= REARM_TICKS;
                lim_reg[p] <= 13'h0000;
            end
            boost_reg <= 2'b00;
            armed_reg <= 2'b11;
            fault_reg <= 2'b00;
            switch_on <= 2'b00;
            soft_start <= 2'b00;
            discharge <= 2'b11;
            secondary_sel <= 2'b00;
            limiting <= 2'b00;
            port_fault_flag_out <= 2'b00;
            port_fault_flag_oe <= 2'b00;
        end else begin
            for (int p = 0; p < 2; p++) begin
                st_reg[p] <= st_next[p];
                tmr_reg[p] <= tmr_next[p];
                bst_reg[p] <= bst_next[p];
                rearm_reg[p] <= rearm_next[p];
                lim_reg[p] <= lim_next[p];
                switch_on[p] <= (st_next[p] == ST_SOFT || st_next[p] == ST_RUN);
                soft_start[p] <= (st_next[p] == ST_SOFT);
                discharge[p] <= (st_next[p] == ST_OFF);
                limiting[p] <= lim_now[p];
            end
            boost_reg <= boost_next;
            armed_reg <= armed_next;
            fault_reg <= fault_next;
            secondary_sel <= boost_next;
            port_fault_flag_out <= 2'b00;
            port_fault_flag_oe <= fault_next;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    localparam int FOC = FAST_OFF_CYCLES;

    for (genvar g = 0; g < 2; g++) begin : g_chk
        sequence s_hiccup_done;
            st_reg[g] == ST_HICCUP ##1 st_reg[g] == ST_SOFT;
        endsequence
        property p_fast_off;
            @(posedge clock) disable iff (!nrst)
            $rose(over_fast[g]) ##1 over_fast[g] [*3] |-> ##[0:FOC] !switch_on[g];
        endproperty
        a_fast_off: assert property (p_fast_off) else $error("port not off after fast trip");
        property p_over_sec;
            @(posedge clock) disable iff (!nrst)
            boost_reg[g] && sen[g].over_sec |=> !boost_reg[g] && !secondary_sel[g];
        endproperty
        a_over_sec: assert property (p_over_sec) else $error("boost kept above secondary");
        property p_interlock;
            @(posedge clock) disable iff (!nrst)
            sen[1-g].over_pri |=> !boost_reg[g];
        endproperty
        a_interlock: assert property (p_interlock) else $error("both ports boosted");
        property p_boost_end;
            @(posedge clock) disable iff (!nrst)
            boost_reg[g] |-> bst_reg[g] < BOOST_TICKS;
        endproperty
        a_boost_end: assert property (p_boost_end) else $error("boost window overrun");
        property p_rearm;
            @(posedge clock) disable iff (!nrst)
            $rose(boost_reg[g]) |-> $past(rearm_reg[g]) >= REARM_TICKS;
        endproperty
        a_rearm: assert property (p_rearm) else $error("secondary re-armed early");
        property p_hiccup_off;
            @(posedge clock) disable iff (!nrst)
            s_hiccup_done |-> $past(tmr_reg[g], 1) == 13'(HIC_TICKS - 1) && switch_on[g];
        endproperty
        a_hiccup_off: assert property (p_hiccup_off) else $error("hiccup off time wrong");
        property p_fault;
            @(posedge clock) disable iff (!nrst)
            (st_reg[g] == ST_HICCUP || st_reg[g] == ST_HOT) |-> port_fault_flag_oe[g] && !switch_on[g];
        endproperty
        a_fault: assert property (p_fault) else $error("fault flag not driven in fault");
        property p_hot;
            @(posedge clock) disable iff (!nrst)
            st_reg[g] == ST_RUN && sen[g].hot && uvlo_q && sen[g].en |=> st_reg[g] == ST_HOT ##1 !switch_on[g];
        endproperty
        a_hot: assert property (p_hot) else $error("thermal trip ignored");
        property p_disable;
            @(posedge clock) disable iff (!nrst)
            !sen[g].en |=> !switch_on[g] && discharge[g];
        endproperty
        a_disable: assert property (p_disable) else $error("port on while disabled");
    end

endmodule // ulc_port_ctrl

// >>> dv/ulc_load_model.sv
// Behavioural model of the two port loads and of the pass transistor temperatures.
// Assumes the bench sets the demanded current and junction temperature of each port.
module ulc_load_model
    import ulc_pkg::*;
(
    input wire logic [1:0] switch_on,
    input wire logic [1:0] soft_start,
    input wire logic [1:0] secondary_sel,
    input wire logic [15:0] primary_limit,
    input wire logic [15:0] secondary_limit,
    input wire logic [1:0][15:0] load_ma,
    input wire logic [1:0][7:0] temp_c,
    output logic [1:0] over_primary,
    output logic [1:0] over_secondary,
    output logic [1:0] over_fast,
    output logic [1:0] nfet_hot,
    output logic [1:0] nfet_cooled,
    output logic [1:0] vbus_good
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // Comparators seen from the load side
    // ****************************************************************
    // Current flows only through a closed switch, so every comparator except nfet_hot and nfet_cooled drops when the switch opens.
    // Above the secondary limit is reachable only while that limit is in force; otherwise the loop clamps.
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            over_primary[p] = switch_on[p] && (load_ma[p] > primary_limit);
            over_secondary[p] = switch_on[p] && secondary_sel[p] && (load_ma[p] > secondary_limit);
            over_fast[p] = switch_on[p] && (load_ma[p] >= 16'h1F40);
            vbus_good[p] = switch_on[p] && !soft_start[p] && (load_ma[p] <= primary_limit);
            nfet_hot[p] = temp_c[p] > 8'hA0;
            nfet_cooled[p] = temp_c[p] <= 8'h96;
        end
    end
endmodule // ulc_load_model

// >>> dv/tb_top.sv
// Self-checking bench of the two-port current limit controller with a load model.
// Assumes shortened timebase parameters; all expected times are derived from them.
module tb_top
    import ulc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    localparam int TCYC = 4;
    localparam int SW = 0, SS = 1, SEC = 2, LIM = 3, FLT = 4;
    logic clock, nrst, uvlo_ok, limit_set_gnd;
    logic [11:0] res_code;
    logic [1:0] en;
    logic [1:0][15:0] load_ma;
    logic [1:0][7:0] temp_c;
    logic [1:0] over_primary, over_secondary, over_fast, nfet_hot, nfet_cooled, vbus_good;
    logic [1:0] switch_on, soft_start, discharge, secondary_sel, limiting, flag_out, flag_oe;
    logic [15:0] primary_limit, secondary_limit;
    logic [1:0] fault_pin;
    logic [1:0] sec_q = 2'b00, sw_q = 2'b00, fell = 2'b00;
    int bad_count = 0, check_count = 0, cyc = 0;
    int fall_t [2];
    int codes [5] = '{191, 154, 115, 95, 0};

    // The fault pin is open drain with a pull-up, so it reads high whenever no one pulls it.
    assign fault_pin = (flag_oe & flag_out) | ~flag_oe;

    ulc_port_ctrl #(.TICK_CYC(TCYC), .HIC_TICKS(10)) ulc_port_ctrl_i (
        .clock(clock), .nrst(nrst), .uvlo_ok(uvlo_ok), .limit_set_gnd(limit_set_gnd),
        .limit_set_resistor(res_code), .port_enable_input(en), .over_primary(over_primary),
        .over_secondary(over_secondary), .over_fast(over_fast), .nfet_hot(nfet_hot),
        .nfet_cooled(nfet_cooled), .vbus_good(vbus_good), .switch_on(switch_on),
        .soft_start(soft_start), .discharge(discharge), .secondary_sel(secondary_sel),
        .limiting(limiting), .port_fault_flag_out(flag_out), .port_fault_flag_oe(flag_oe),
        .primary_limit(primary_limit), .secondary_limit(secondary_limit));

    ulc_load_model ulc_load_model_i (
        .switch_on(switch_on), .soft_start(soft_start), .secondary_sel(secondary_sel),
        .primary_limit(primary_limit), .secondary_limit(secondary_limit), .load_ma(load_ma),
        .temp_c(temp_c), .over_primary(over_primary), .over_secondary(over_secondary),
        .over_fast(over_fast), .nfet_hot(nfet_hot), .nfet_cooled(nfet_cooled), .vbus_good(vbus_good));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic int exp_pri(input int code, input logic gnd);
        return (gnd || code == 0) ? 3550 : 322730 / code;
    endfunction

    function automatic logic sig(input int sel, input int p);
        case (sel)
            SW: return switch_on[p];
            SS: return soft_start[p];
            SEC: return secondary_sel[p];
            LIM: return limiting[p];
            default: return flag_oe[p];
        endcase
    endfunction

    // Waits a bounded number of edges for a port output, then compares it, so a hang shows as a mismatch.
    task automatic wait_sig(input int sel, input int p, input logic v, input int maxc, output int n);
        n = 0;
        while (sig(sel, p) !== v && n < maxc) begin
            @(posedge clock);
            #1;
            n++;
        end
        check($sformatf("output_%0d_port_%0d", sel, p), 32'(sig(sel, p)), 32'(v));
    endtask

    task automatic setl(input int p, input int ma);
        @(negedge clock);
        load_ma[p] = 16'(ma);
    endtask

    // ****************************************************************
    // Clock, watchdog and running monitor
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // The whole run is about 1000 cycles; ten times that means a hang.
    initial begin
        #1_000_000;
        bad_count++;
        print_verdict();
    end

    // Watches every boost end and every switch turn-on for the whole run, whatever the scenario.
    always begin
        @(posedge clock);
        #1;
        cyc++;
        for (int p = 0; p < 2; p++) begin
            if (nrst === 1'b1 && sec_q[p] && !secondary_sel[p]) begin
                fall_t[p] = cyc;
                fell[p] = 1'b1;
            end
            if (nrst === 1'b1 && !sec_q[p] && secondary_sel[p] && fell[p]) begin
                check("rearm_gap", 32'(cyc - fall_t[p] >= 620), 32'h1);
            end
            if (nrst === 1'b1 && !sw_q[p] && switch_on[p]) begin
                check("soft_at_turn_on", 32'(soft_start[p]), 32'h1);
            end
        end
        sec_q = secondary_sel;
        sw_q = switch_on;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        int n;
        nrst = 1'b0;
        uvlo_ok = 1'b0;
        limit_set_gnd = 1'b1;
        res_code = 12'h000;
        en = 2'b00;
        load_ma = '0;
        temp_c = {8'h19, 8'h19};
        void'($urandom(32'h707D));
        repeat (16) @(posedge clock);
        #1;
        check("discharge_in_reset", 32'(discharge), 32'h3);
        check("primary_in_reset", 32'(primary_limit), 32'h0DDE);
        check("fault_oe_in_reset", 32'(flag_oe), 32'h0);
        @(negedge clock);
        nrst = 1'b1;
        // Table settings, a zero code, random codes and finally the grounded input.
        for (int i = 0; i < 8; i++) begin
            @(negedge clock);
            limit_set_gnd = (i == 7);
            res_code = (i < 5) ? 12'(codes[i]) : 12'(20 + $urandom % 381);
            repeat (8) @(posedge clock);
            #1;
            check("primary_limit", 32'(primary_limit), 32'(exp_pri(res_code, limit_set_gnd)));
            check("secondary_limit", 32'(secondary_limit), 32'(exp_pri(res_code, limit_set_gnd) * 8 / 5));
        end
        // Port B draws between the limits at power-up while port A carries a light random load.
        @(negedge clock);
        load_ma[1] = 16'h0FA0;
        load_ma[0] = 16'($urandom % 3000);
        uvlo_ok = 1'b1;
        en = 2'b11;
        wait_sig(SW, 1, 1'b1, 20, n);
        check("boost_at_start", 32'(secondary_sel[1]), 32'h1);
        repeat (8) @(posedge clock);
        #1;
        check("interlock", 32'(secondary_sel[0]), 32'h0);
        check("no_limit_in_boost", 32'(limiting[1]), 32'h0);
        check("other_port_on", 32'(switch_on[0]), 32'h1);
        wait_sig(SEC, 1, 1'b0, 120, n);
        check("boost_length", 32'(n + 8 >= 72 && n + 8 <= 88), 32'h1);
        wait_sig(LIM, 1, 1'b1, 4, n);
        wait_sig(SW, 1, 1'b0, 220, n);
        check("persist_time", 32'(n >= 158 && n <= 170), 32'h1);
        check("fault_pin_hiccup", 32'(fault_pin[1]), 32'h0);
        check("other_port_keeps_on", 32'(switch_on[0]), 32'h1);
        wait_sig(SW, 1, 1'b1, 80, n);
        check("hiccup_off_time", 32'(n >= 34 && n <= 46), 32'h1);
        wait_sig(SW, 1, 1'b0, 260, n);
        check("hiccup_on_time", 32'(n >= 162 && n <= 172), 32'h1);
        setl(1, 1000);
        wait_sig(SW, 1, 1'b1, 80, n);
        wait_sig(FLT, 1, 1'b0, 100, n);
        check("fault_pin_released", 32'(fault_pin[1]), 32'h1);
        // Port A re-arms, then an inrush above the secondary limit cuts the boost short.
        wait_sig(SEC, 0, 1'b1, 900, n);
        setl(0, 6000);
        wait_sig(SEC, 0, 1'b0, 8, n);
        wait_sig(LIM, 0, 1'b1, 4, n);
        setl(0, 1000);
        // A dead short trips the fast path, then the port ramps back and limits.
        setl(0, 9000);
        wait_sig(SW, 0, 1'b0, 8, n);
        check("fast_off_time", 32'(n <= FAST_OFF_CYCLES), 32'h1);
        setl(0, 4000);
        wait_sig(SW, 0, 1'b1, 16, n);
        wait_sig(LIM, 0, 1'b1, 70, n);
        setl(0, 1000);
        // Thermal cycling on port B with a hold inside the hysteresis band.
        @(negedge clock);
        temp_c[1] = 8'hAA;
        wait_sig(SW, 1, 1'b0, 8, n);
        check("fault_pin_hot", 32'(fault_pin[1]), 32'h0);
        @(negedge clock);
        temp_c[1] = 8'h9B;
        repeat (40) @(posedge clock);
        #1;
        check("stays_off_warm", 32'(switch_on[1]), 32'h0);
        @(negedge clock);
        temp_c[1] = 8'h8C;
        wait_sig(SW, 1, 1'b1, 10, n);
        wait_sig(FLT, 1, 1'b0, 100, n);
        // Disable port A alone, then drop the supply for both.
        @(negedge clock);
        en[0] = 1'b0;
        wait_sig(SW, 0, 1'b0, 8, n);
        check("discharge_port_a", 32'(discharge[0]), 32'h1);
        check("port_b_unaffected", 32'(switch_on[1]), 32'h1);
        @(negedge clock);
        uvlo_ok = 1'b0;
        repeat (8) @(posedge clock);
        #1;
        check("discharge_in_uvlo", 32'(discharge), 32'h3);
        print_verdict();
    end
endmodule // tb_top
